//--- rtl/fcs_busy_timer.v
`timescale 1ns/1ps
// Down counter that holds the controller busy for a set time
module fcs_busy_timer #(
    parameter W = 32
) (
    input  wire         clk,
    input  wire         reset,
    input  wire         load,
    input  wire [W-1:0] loadVal,
    output wire         done
);
    reg [W-1:0] cnt_q;  // Cycles still to wait

    // Load wins; otherwise count down to zero and stop
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= {W{1'b0}};
        end else if (load) begin
            cnt_q <= loadVal;
        end else if (cnt_q != {W{1'b0}}) begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (cnt_q == {W{1'b0}});
endmodule

//--- rtl/fcs_flash_array.v
`timescale 1ns/1ps
// Word-wide flash array model, one port, registered read data
module fcs_flash_array #(
    parameter AW = 15,
    parameter DW = 16
) (
    input  wire          clk,
    input  wire          en,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [DW-1:0] wdata,
    output reg  [DW-1:0] rdata
);
    reg [DW-1:0] mem [0:(1<<AW)-1];  // Cell storage
    integer i;

    // Array leaves the factory erased
    initial begin
        for (i = 0; i < (1<<AW); i = i + 1) begin
            mem[i] = {DW{1'b1}};
        end
    end

    // Read data holds until the next enabled read; enabled writes leave it
    always @(posedge clk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end else begin
                rdata <= mem[addr];
            end
        end
    end
endmodule

//--- rtl/fcs_flash_command_sequencer.v
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "fcs_regs.vh"
module fcs_flash_command_sequencer #(
    parameter        AW          = 15,
    parameter [31:0] ERWR_CYCLES = `FCS_ERWR_US * `FCS_CLK_MHZ,
    parameter [31:0] PE_CYCLES   = `FCS_ERWR_US * `FCS_CLK_MHZ,
    parameter [31:0] MASS_CYCLES = `FCS_MASS_US * `FCS_CLK_MHZ,
    parameter [31:0] SIG_CYCLES  = `FCS_SIG_CYCLES
) (
    input  wire        clk,
    input  wire        reset,
    input  wire [27:0] busAddr,
    input  wire [31:0] busWrData,
    input  wire        busWrStb,
    input  wire        busRdStb,
    output wire [31:0] busRdData,
    output wire        flashIrq
);
    // Short enough to stay a constant
    localparam [31:0] WR_CYCLES = `FCS_WRITE_US * `FCS_CLK_MHZ;
    localparam [AW:0] PAGE_LEN  = `FCS_PAGE_WORDS;
    localparam [AW:0] USER_LEN  = (1 << AW) - `FCS_KERN_WORDS;
    localparam [AW:0] ALL_LEN   = (1 << AW);
    localparam [AW:0] ONE_W     = 1;

    localparam [1:0] S_IDLE = 2'b00;
    localparam [1:0] S_RUN  = 2'b01;
    localparam [1:0] S_FIN  = 2'b10;

    // Software visible state
    reg  [8:0]    mode_q;       // Mode control, bits 8..0
    reg  [7:0]    cmd_q;        // Command register
    reg  [15:0]   data_q;       // Data word, not reset
    reg  [15:0]   addr_q;       // Address word
    reg  [31:0]   protReg_q;    // Protection value to save
    reg  [23:0]   sig_q;        // Signature result
    reg           pass_q;       // Command passed
    reg           fail_q;       // Command failed or mismatch
    reg           irqFlag_q;    // Sticky interrupt flag
    reg           flashIrq_q;   // Completion pulse
    reg  [31:0]   rdData_q;     // Bus read data
    // Sequencer state
    reg  [1:0]    state_q;      // Sequencer state
    reg  [7:0]    op_q;         // Running command
    reg           opOk_q;       // Command passed its checks
    reg  [AW-1:0] walkAddr_q;   // Erase or signature walker
    reg  [AW:0]   walkLeft_q;   // Words still to walk
    reg           walkWr_q;     // Walker writes erased value
    reg           sigVal_q;     // Walker read data due
    // Protection state
    reg  [31:0]   effProt_q;    // Protection in force
    reg           protLoad_q;   // Pending load after reset
    // Nonvolatile cells, they survive reset like flash bits
    reg  [31:0]   savedProt_q = `FCS_PROT_OPEN;
    reg  [31:0]   key_q       = `FCS_KEY_BLANK;
    reg           keySet_q    = 1'b0;

    // Decode of the current bus access
    wire [7:0]  code    = busWrData[7:0];
    wire        cmdWr   = busWrStb && (busAddr == `FCS_OFF_CMD);
    wire        startOp = cmdWr && (state_q == S_IDLE);
    wire        statRd  = busRdStb && (busAddr == `FCS_OFF_STATUS);
    wire        finDone = (state_q == S_FIN);
    wire        busy    = (state_q != S_IDLE);
    wire [4:0]  grp     = addr_q[15:11];
    wire [31:0] keyIn   = {addr_q, data_q};
    wire [AW-1:0] pageBase = {addr_q[AW:9], 8'h00};
    wire [15:0] memRdata;
    wire        tmrDone;

    // Top group is kernel space and is never written
    wire wrAllowed = mode_q[`FCS_MODE_WREN] && (grp != 5'h1f) && effProt_q[grp];
    wire rdAllowed = effProt_q[`FCS_PROT_RDBIT];
    // Guard words must be in place before the code lands
    wire massKey = mode_q[`FCS_MODE_WREN] && (data_q == `FCS_MASS_DATA) && (addr_q == `FCS_MASS_ADDR);
    // First save is free; later ones need the key; permanent key locks
    wire protAllowed = !keySet_q || (mode_q[`FCS_MODE_KEYEN] && !mode_q[`FCS_MODE_KEYB5]
                       && (keyIn == key_q) && (key_q != `FCS_KEY_PERM));

    // Per-command setup
    reg          known;
    reg          allow;
    reg [31:0]   dur;
    reg [AW:0]   wl;
    reg [AW-1:0] wa;
    reg          ww;
    always @* begin
        known = 1'b1;
        allow = 1'b1;
        dur   = 32'h00000001;
        wl    = {(AW+1){1'b0}};
        wa    = {AW{1'b0}};
        ww    = 1'b0;
        case (code)
            `FCS_CMD_READ, `FCS_CMD_VERIFY: begin
                allow = rdAllowed;
            end
            `FCS_CMD_WRITE: begin
                allow = wrAllowed;
                dur   = WR_CYCLES;
            end
            `FCS_CMD_ERWR: begin
                allow = wrAllowed;
                dur   = ERWR_CYCLES;
                wl    = PAGE_LEN;
                wa    = pageBase;
                ww    = 1'b1;
            end
            `FCS_CMD_PERASE: begin
                allow = wrAllowed;
                dur   = PE_CYCLES;
                wl    = PAGE_LEN;
                wa    = pageBase;
                ww    = 1'b1;
            end
            `FCS_CMD_MASS: begin
                allow = massKey;
                dur   = MASS_CYCLES;
                wl    = USER_LEN;
                ww    = 1'b1;
            end
            `FCS_CMD_SIGN: begin
                dur = SIG_CYCLES;
                wl  = ALL_LEN;
            end
            `FCS_CMD_PROT: begin
                allow = protAllowed;
            end
            `FCS_CMD_PING: begin
                allow = 1'b1;
            end
            default: begin
                // Null and reserved codes start nothing
                known = 1'b0;
            end
        endcase
    end

    // Array port steering
    reg          memEn;
    reg          memWe;
    reg [AW-1:0] memAddr;
    reg [15:0]   memWd;
    always @* begin
        memEn   = 1'b0;
        memWe   = 1'b0;
        memAddr = addr_q[AW:1];
        memWd   = data_q;
        if (state_q == S_IDLE) begin
            // Fetch early so the word waits in the array output
            if (startOp && (code == `FCS_CMD_READ || code == `FCS_CMD_VERIFY) && rdAllowed) begin
                memEn = 1'b1;
            end
        end else if (state_q == S_RUN) begin
            if (walkLeft_q != {(AW+1){1'b0}}) begin
                memEn   = 1'b1;
                memWe   = walkWr_q;
                memAddr = walkAddr_q;
                memWd   = `FCS_ERASED;
            end
        end else if (finDone && opOk_q && (op_q == `FCS_CMD_WRITE || op_q == `FCS_CMD_ERWR)) begin
            memEn = 1'b1;
            memWe = 1'b1;
        end
    end

    fcs_flash_array #(
        .AW (AW),
        .DW (16)
    ) uArray (
        .clk   (clk),
        .en    (memEn),
        .we    (memWe),
        .addr  (memAddr),
        .wdata (memWd),
        .rdata (memRdata)
    );

    fcs_busy_timer #(
        .W (32)
    ) uTimer (
        .clk     (clk),
        .reset   (reset),
        .load    (startOp && known),
        .loadVal (allow ? dur : 32'h00000001),
        .done    (tmrDone)
    );

    // Outcome of the finishing cycle
    wire verifyBad = (op_q == `FCS_CMD_VERIFY) && (memRdata != data_q);
    wire passSet   = finDone && opOk_q && !verifyBad;
    wire failSet   = finDone && !passSet;
    wire irqSet    = finDone && mode_q[`FCS_MODE_IRQEN];

    // Sequencer: idle, run until timer and walker both finish, finish
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q    <= S_IDLE;
            op_q       <= `FCS_CMD_NULL;
            opOk_q     <= 1'b0;
            walkAddr_q <= {AW{1'b0}};
            walkLeft_q <= {(AW+1){1'b0}};
            walkWr_q   <= 1'b0;
            sigVal_q   <= 1'b0;
            sig_q      <= `FCS_RST_SIGN;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (startOp && known) begin
                        state_q    <= S_RUN;
                        op_q       <= code;
                        opOk_q     <= allow;
                        walkAddr_q <= wa;
                        walkLeft_q <= allow ? wl : {(AW+1){1'b0}};
                        walkWr_q   <= ww;
                        if (code == `FCS_CMD_SIGN) begin
                            sig_q <= `FCS_RST_SIGN;
                        end
                    end
                end
                S_RUN: begin
                    sigVal_q <= (walkLeft_q != {(AW+1){1'b0}}) && !walkWr_q;
                    if (walkLeft_q != {(AW+1){1'b0}}) begin
                        walkAddr_q <= walkAddr_q + {{(AW-1){1'b0}}, 1'b1};
                        walkLeft_q <= walkLeft_q - ONE_W;
                    end
                    // Rotate-and-fold keeps word order in the result
                    if (sigVal_q) begin
                        sig_q <= {sig_q[22:0], sig_q[23]} ^ {8'h00, memRdata};
                    end
                    // Timer alone sets the length unless shortened below the walk
                    if (tmrDone && walkLeft_q == {(AW+1){1'b0}} && !sigVal_q) begin
                        state_q <= S_FIN;
                    end
                end
                S_FIN: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Software registers and status flags
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_q     <= `FCS_RST_MODE;
            cmd_q      <= `FCS_RST_CMD;
            addr_q     <= `FCS_RST_ADDR;
            protReg_q  <= `FCS_RST_PROT;
            pass_q     <= 1'b0;
            fail_q     <= 1'b0;
            irqFlag_q  <= 1'b0;
            flashIrq_q <= 1'b0;
        end else begin
            if (busWrStb && busAddr == `FCS_OFF_MODE) begin
                mode_q <= busWrData[8:0];
            end
            if (busWrStb && busAddr == `FCS_OFF_ADDR) begin
                addr_q <= busWrData[15:0];
            end
            if (busWrStb && busAddr == `FCS_OFF_PROT) begin
                protReg_q <= busWrData;
            end
            // Command writes while busy are dropped
            if (startOp) begin
                cmd_q <= (code == `FCS_CMD_NULL) ? `FCS_CMD_DONE : code;
            end else if (finDone && op_q <= `FCS_CMD_MASS) begin
                cmd_q <= `FCS_CMD_DONE;
            end
            // Set beats a clearing read in the same cycle
            pass_q     <= passSet | (pass_q & ~statRd);
            fail_q     <= failSet | (fail_q & ~statRd);
            irqFlag_q  <= irqSet | (irqFlag_q & ~statRd);
            flashIrq_q <= irqSet;
        end
    end

    // Data word has no reset value
    always @(posedge clk) begin
        if (finDone && opOk_q && op_q == `FCS_CMD_READ) begin
            data_q <= memRdata;
        end else if (busWrStb && busAddr == `FCS_OFF_DATA) begin
            data_q <= busWrData[15:0];
        end
    end

    // Nonvolatile protection cells
    always @(posedge clk) begin
        if (finDone && opOk_q && op_q == `FCS_CMD_PROT) begin
            savedProt_q <= protReg_q;
            key_q       <= keyIn;
            keySet_q    <= 1'b1;
        end else if (finDone && opOk_q && op_q == `FCS_CMD_MASS) begin
            savedProt_q <= `FCS_PROT_OPEN;
            key_q       <= `FCS_KEY_BLANK;
            keySet_q    <= 1'b0;
        end
    end

    // Protection in force: all guarded until loaded after reset
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            effProt_q  <= 32'h00000000;
            protLoad_q <= 1'b1;
        end else if (protLoad_q) begin
            effProt_q  <= savedProt_q;
            protLoad_q <= 1'b0;
        end else if (finDone && opOk_q && op_q == `FCS_CMD_MASS) begin
            effProt_q <= `FCS_PROT_OPEN;
        end
    end

    // Read mux, answered one cycle after the strobe
    reg [31:0] rdMux;
    always @* begin
        case (busAddr)
            `FCS_OFF_STATUS: rdMux = {28'h0000000, irqFlag_q, busy, fail_q, pass_q};
            `FCS_OFF_MODE:   rdMux = {23'h000000, mode_q};
            `FCS_OFF_CMD:    rdMux = {24'h000000, cmd_q};
            `FCS_OFF_DATA:   rdMux = {16'h0000, data_q};
            `FCS_OFF_ADDR:   rdMux = {16'h0000, addr_q};
            `FCS_OFF_SIGN:   rdMux = {8'h00, sig_q};
            `FCS_OFF_PROT:   rdMux = protReg_q;
            default:         rdMux = 32'h00000000;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData_q <= 32'h00000000;
        end else begin
            rdData_q <= busRdStb ? rdMux : 32'h00000000;
        end
    end

    assign busRdData = rdData_q;
    assign flashIrq  = flashIrq_q;
endmodule

//--- rtl/fcs_regs.vh
`ifndef FCS_REGS_VH
`define FCS_REGS_VH

// Register byte offsets
`define FCS_OFF_STATUS  28'hffff800
`define FCS_OFF_MODE    28'hffff804
`define FCS_OFF_CMD     28'hffff808
`define FCS_OFF_DATA    28'hffff80c
`define FCS_OFF_ADDR    28'hffff810
`define FCS_OFF_SIGN    28'hffff818
`define FCS_OFF_PROT    28'hffff81c

// Reset values
`define FCS_RST_MODE    9'h000
`define FCS_RST_CMD     8'h07
`define FCS_RST_ADDR    16'h0000
`define FCS_RST_PROT    32'h00000000
`define FCS_RST_SIGN    24'hffffff

// Mode register bit positions
`define FCS_MODE_KEYB5  5
`define FCS_MODE_KEYEN  6
`define FCS_MODE_IRQEN  4
`define FCS_MODE_WREN   3

// Status register bit positions
`define FCS_ST_PASS     0
`define FCS_ST_FAIL     1
`define FCS_ST_BUSY     2
`define FCS_ST_IRQ      3

// Command codes
`define FCS_CMD_NULL    8'h00
`define FCS_CMD_READ    8'h01
`define FCS_CMD_WRITE   8'h02
`define FCS_CMD_ERWR    8'h03
`define FCS_CMD_VERIFY  8'h04
`define FCS_CMD_PERASE  8'h05
`define FCS_CMD_MASS    8'h06
`define FCS_CMD_DONE    8'h07
`define FCS_CMD_SIGN    8'h0b
`define FCS_CMD_PROT    8'h0c
`define FCS_CMD_PING    8'h0f

// Keys and special words
`define FCS_MASS_DATA   16'h3cff
`define FCS_MASS_ADDR   16'hffc3
`define FCS_KEY_PERM    32'hdeaddead
`define FCS_KEY_BLANK   32'hffffffff
`define FCS_PROT_OPEN   32'hffffffff
`define FCS_PROT_RDBIT  31
`define FCS_ERASED      16'hffff

// Timing
`define FCS_CLK_MHZ     40
`define FCS_WRITE_US    50
`define FCS_ERWR_US     24000
`define FCS_MASS_US     2480000
`define FCS_SIG_CYCLES  32778

// Array geometry in 16-bit words
`define FCS_PAGE_WORDS  256
`define FCS_KERN_WORDS  1024

`endif

//--- testbench/fcs_bus_master.sv
`timescale 1ns/1ps
// Processor side of the register port; one access per task call
module fcs_bus_master (
    input  wire        clk,
    output reg  [27:0] busAddr,
    output reg  [31:0] busWrData,
    output reg         busWrStb,
    output reg         busRdStb,
    input  wire [31:0] busRdData
);
    // Idle bus from time zero
    initial begin
        busAddr   = 28'h0000000;
        busWrData = 32'h00000000;
        busWrStb  = 1'b0;
        busRdStb  = 1'b0;
    end

    // One-cycle write strobe beside address and data
    task wr(input [27:0] a, input [31:0] d);
        @(posedge clk);
        busWrStb  <= 1'b1;
        busAddr   <= a;
        busWrData <= d;
        @(posedge clk);
        busWrStb  <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe, so sample just then
    task rd(input [27:0] a, output [31:0] d);
        @(posedge clk);
        busRdStb <= 1'b1;
        busAddr  <= a;
        @(posedge clk);
        busRdStb <= 1'b0;
        #1;
        d = busRdData;
    endtask
endmodule

//--- testbench/fcs_cmd_checker.sv
`timescale 1ns/1ps
`include "fcs_regs.vh"
// Port-level checks of command timing, interrupt pulse and read slot
module fcs_cmd_checker #(
    parameter [31:0] ERWR_CYCLES = 32'h0000012c,
    parameter [31:0] PE_CYCLES   = 32'h0000012c,
    parameter [31:0] MASS_CYCLES = 32'h00007d00
) (
    input wire        clk,
    input wire        reset,
    input wire [27:0] busAddr,
    input wire [31:0] busWrData,
    input wire        busWrStb,
    input wire        busRdStb,
    input wire [31:0] busRdData,
    input wire        flashIrq
);
    reg        irqEn_q;  // Mode bit 4 as last written
    reg        wrEn_q;   // Mode bit 3 as last written
    reg [15:0] data_q;   // Data word as last written
    reg [15:0] addr_q;   // Address word as last written
    reg [7:0]  code_q;   // Last command code
    reg [15:0] cnt_q;    // Cycles since last command write, saturating
    wire       cmdWr  = busWrStb && busAddr == `FCS_OFF_CMD;
    wire [7:0] code   = busWrData[7:0];
    wire       rsvd   = code == 8'h00 || (code >= 8'h07 && code <= 8'h0a) || code == 8'h0d || code == 8'h0e || code > 8'h0f;
    wire       shortOp = code == 8'h01 || code == 8'h04 || code == 8'h0f;
    // Mass erase only counts as accepted with both key words in place
    wire       keysOk = wrEn_q && data_q == `FCS_MASS_DATA && addr_q == `FCS_MASS_ADDR;

    // Shadow of software settings; the read command also loads data, so
    // the mass-erase expectation relies on the bench writing data first
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            irqEn_q <= 1'b0;
            wrEn_q  <= 1'b0;
            data_q  <= 16'h0000;
            addr_q  <= 16'h0000;
            code_q  <= 8'h00;
            cnt_q   <= 16'hffff;
        end else begin
            if (busWrStb && busAddr == `FCS_OFF_MODE) begin
                irqEn_q <= busWrData[4];
                wrEn_q  <= busWrData[3];
            end
            if (busWrStb && busAddr == `FCS_OFF_DATA) begin
                data_q <= busWrData[15:0];
            end
            if (busWrStb && busAddr == `FCS_OFF_ADDR) begin
                addr_q <= busWrData[15:0];
            end
            if (cmdWr) begin
                code_q <= code;
            end
            cnt_q <= cmdWr ? 16'h0000 : cnt_q + {15'h0000, cnt_q != 16'hffff};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_rd_idle; !busRdStb |=> busRdData == 32'h00000000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");
    property p_irq_en; flashIrq |-> irqEn_q; endproperty
    a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
    property p_irq_pulse; flashIrq |=> !flashIrq; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
    property p_short_cmd; cmdWr && shortOp && irqEn_q |-> !flashIrq ##1 !flashIrq ##1 !flashIrq ##1 !flashIrq ##1 flashIrq; endproperty
    a_short_cmd: assert property (p_short_cmd) else $error("short command interrupt not at fourth cycle");
    property p_write_time; flashIrq && code_q == 8'h02 |-> cnt_q == (wrEn_q ? `FCS_WRITE_US * `FCS_CLK_MHZ + 2 : 3); endproperty
    a_write_time: assert property (p_write_time) else $error("write duration wrong");
    property p_erwr_time; flashIrq && code_q == 8'h03 |-> cnt_q == (wrEn_q ? ERWR_CYCLES + 32'd2 : 32'd3); endproperty
    a_erwr_time: assert property (p_erwr_time) else $error("erase-write duration wrong");
    property p_perase_time; flashIrq && code_q == 8'h05 |-> cnt_q == (wrEn_q ? PE_CYCLES + 32'd2 : 32'd3); endproperty
    a_perase_time: assert property (p_perase_time) else $error("page erase duration wrong");
    property p_mass_time; flashIrq && code_q == 8'h06 |-> cnt_q == (keysOk ? MASS_CYCLES + 32'd2 : 32'd3); endproperty
    a_mass_time: assert property (p_mass_time) else $error("mass erase duration wrong");
    property p_reserved; cmdWr && rsvd |=> !flashIrq [*4]; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code raised interrupt");

    c_ping: cover property (cmdWr && code == 8'h0f && irqEn_q);
    c_mass: cover property (flashIrq && code_q == 8'h06 && keysOk);
    c_rsvd: cover property (cmdWr && rsvd);
endmodule

bind fcs_flash_command_sequencer fcs_cmd_checker #(
    .ERWR_CYCLES(ERWR_CYCLES),
    .PE_CYCLES  (PE_CYCLES),
    .MASS_CYCLES(MASS_CYCLES)
) u_fcs_cmd_checker (
    .clk      (clk),
    .reset    (reset),
    .busAddr  (busAddr),
    .busWrData(busWrData),
    .busWrStb (busWrStb),
    .busRdStb (busRdStb),
    .busRdData(busRdData),
    .flashIrq (flashIrq)
);

//--- testbench/test_flash_command_sequencer.sv
`timescale 1ns/1ps
`include "fcs_regs.vh"
// Self-checking bench for the flash command sequencer
module test_flash_command_sequencer;
    reg         clk;        // 40 MHz clock
    reg         reset;      // Async reset, active high
    wire [27:0] busAddr;
    wire [31:0] busWrData;
    wire        busWrStb;
    wire        busRdStb;
    wire [31:0] busRdData;
    wire        flashIrq;
    integer     error_cnt;
    integer     checked;
    integer     seed;
    integer     i;
    reg  [31:0] rv;         // Raw random draw
    reg  [31:0] got;        // Last read value
    reg  [15:0] a;          // Word byte address under test
    reg  [15:0] d;          // Data word under test

    // Short counts keep the long erases inside the run budget
    fcs_flash_command_sequencer #(
        .ERWR_CYCLES(32'h0000012c),
        .PE_CYCLES  (32'h0000012c),
        .MASS_CYCLES(32'h00007d00),
        .SIG_CYCLES (32'h0000000a)
    ) u_fcs_flash_command_sequencer (
        .clk(clk), .reset(reset), .busAddr(busAddr), .busWrData(busWrData),
        .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData), .flashIrq(flashIrq)
    );

    fcs_bus_master u_fcs_bus_master (
        .clk(clk), .busAddr(busAddr), .busWrData(busWrData),
        .busWrStb(busWrStb), .busRdStb(busRdStb), .busRdData(busRdData)
    );

    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Status word expected after a command: irq, busy, fail, pass
    function [31:0] st(input p, input q);
        st = {28'h0000000, q, 1'b0, ~p, p};
    endfunction

    task stop_test;
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
        checked = checked + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
        end
    endtask

    task rdc(input [27:0] ad, input [31:0] e, input [63:0] nm);
        u_fcs_bus_master.rd(ad, got);
        chk(nm, e, got);
    endtask

    // Issue a command, see busy, then poll until idle and check the flags
    task cmd(input [7:0] c, input [31:0] e);
        integer n;
        u_fcs_bus_master.wr(`FCS_OFF_CMD, {24'h000000, c});
        u_fcs_bus_master.rd(`FCS_OFF_STATUS, got);
        chk("busy", 32'h00000004, got & 32'h00000004);
        for (n = 0; n < 20000 && got[2] !== 1'b0; n = n + 1) u_fcs_bus_master.rd(`FCS_OFF_STATUS, got);
        chk("status", e, got);
    endtask

    // Hang guard, well above the expected run length
    initial begin
        #(25 * 95000);
        error_cnt = error_cnt + 1;
        stop_test;
    end

    initial begin
        seed = 32'h181f754e;
        error_cnt = 0;
        checked = 0;
        reset = 1'b1;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        rdc(`FCS_OFF_MODE, 32'h00000000, "mode");
        rdc(`FCS_OFF_CMD, 32'h00000007, "cmd");
        rdc(`FCS_OFF_PROT, 32'h00000000, "prot");
        rdc(`FCS_OFF_STATUS, 32'h00000000, "status");
        rdc(28'hffff8fc, 32'h00000000, "unmapped");
        rv = $random(seed);
        u_fcs_bus_master.wr(`FCS_OFF_DATA, rv);
        rdc(`FCS_OFF_DATA, {16'h0000, rv[15:0]}, "data");
        u_fcs_bus_master.wr(`FCS_OFF_MODE, 32'h00000018);
        // Random words outside the kernel: program, read back, verify
        for (i = 0; i < 3; i = i + 1) begin
            rv = $random(seed);
            a = rv[15:0] & 16'h77fe;
            d = rv[31:16];
            u_fcs_bus_master.wr(`FCS_OFF_ADDR, {16'h0000, a});
            u_fcs_bus_master.wr(`FCS_OFF_DATA, {16'h0000, d});
            cmd(8'h02, st(1'b1, 1'b1));
            u_fcs_bus_master.wr(`FCS_OFF_DATA, {16'h0000, ~d});
            cmd(8'h01, st(1'b1, 1'b1));
            rdc(`FCS_OFF_DATA, {16'h0000, d}, "rdword");
            rdc(`FCS_OFF_CMD, 32'h00000007, "cmd");
            cmd(8'h04, st(1'b1, 1'b1));
            u_fcs_bus_master.wr(`FCS_OFF_DATA, {16'h0000, d ^ 16'h0001});
            cmd(8'h04, st(1'b0, 1'b1));
        end
        // Erase-write clears the page around the written word
        d = $random(seed);
        u_fcs_bus_master.wr(`FCS_OFF_DATA, {16'h0000, d});
        cmd(8'h03, st(1'b1, 1'b1));
        cmd(8'h01, st(1'b1, 1'b1));
        rdc(`FCS_OFF_DATA, {16'h0000, d}, "erwr");
        u_fcs_bus_master.wr(`FCS_OFF_ADDR, {16'h0000, a ^ 16'h0002});
        cmd(8'h01, st(1'b1, 1'b1));
        rdc(`FCS_OFF_DATA, {16'h0000, `FCS_ERASED}, "erwrpg");
        u_fcs_bus_master.wr(`FCS_OFF_ADDR, {16'h0000, a});
        cmd(8'h05, st(1'b1, 1'b1));
        cmd(8'h01, st(1'b1, 1'b1));
        rdc(`FCS_OFF_DATA, {16'h0000, `FCS_ERASED}, "perase");
        // Write refused with the enable bit clear
        u_fcs_bus_master.wr(`FCS_OFF_MODE, 32'h00000010);
        u_fcs_bus_master.wr(`FCS_OFF_DATA, {16'h0000, d});
        cmd(8'h02, st(1'b0, 1'b1));
        cmd(8'h01, st(1'b1, 1'b1));
        rdc(`FCS_OFF_DATA, {16'h0000, `FCS_ERASED}, "guard");
        // Reserved code: stored, no run, no flags
        u_fcs_bus_master.wr(`FCS_OFF_MODE, 32'h00000000);
        u_fcs_bus_master.wr(`FCS_OFF_CMD, 32'h00000008);
        repeat (4) @(posedge clk);
        rdc(`FCS_OFF_STATUS, 32'h00000000, "rsvdst");
        rdc(`FCS_OFF_CMD, 32'h00000008, "rsvdcmd");
        cmd(8'h01, st(1'b1, 1'b0));
        rdc(`FCS_OFF_DATA, {16'h0000, `FCS_ERASED}, "rsvdwd");
        cmd(8'h0f, st(1'b1, 1'b0));
        u_fcs_bus_master.wr(`FCS_OFF_MODE, 32'h00000010);
        cmd(8'h0f, st(1'b1, 1'b1));
        // Mass erase: refused without keys, then run with them
        u_fcs_bus_master.wr(`FCS_OFF_MODE, 32'h00000018);
        u_fcs_bus_master.wr(`FCS_OFF_DATA, {16'h0000, d});
        cmd(8'h02, st(1'b1, 1'b1));
        u_fcs_bus_master.wr(`FCS_OFF_DATA, 32'h00000000);
        u_fcs_bus_master.wr(`FCS_OFF_ADDR, {16'h0000, `FCS_MASS_ADDR});
        cmd(8'h06, st(1'b0, 1'b1));
        u_fcs_bus_master.wr(`FCS_OFF_DATA, {16'h0000, `FCS_MASS_DATA});
        cmd(8'h06, st(1'b1, 1'b1));
        u_fcs_bus_master.wr(`FCS_OFF_ADDR, {16'h0000, a});
        cmd(8'h01, st(1'b1, 1'b1));
        rdc(`FCS_OFF_DATA, {16'h0000, `FCS_ERASED}, "mass");
        cmd(8'h0b, st(1'b1, 1'b1));
        // Protection key: first save passes, a wrong key later fails
        u_fcs_bus_master.wr(`FCS_OFF_PROT, 32'hfffffffe);
        rdc(`FCS_OFF_PROT, 32'hfffffffe, "prot");
        u_fcs_bus_master.wr(`FCS_OFF_MODE, 32'h00000048);
        u_fcs_bus_master.wr(`FCS_OFF_ADDR, 32'h00001234);
        u_fcs_bus_master.wr(`FCS_OFF_DATA, 32'h00005678);
        cmd(8'h0c, st(1'b1, 1'b0));
        u_fcs_bus_master.wr(`FCS_OFF_ADDR, 32'h00000000);
        cmd(8'h0c, st(1'b0, 1'b0));
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        u_fcs_bus_master.wr(`FCS_OFF_MODE, 32'h00000008);
        cmd(8'h02, st(1'b0, 1'b0));
        stop_test;
    end
endmodule
